// ### rtl/ipes_irq_top.v
// interrupt priority, external edge and timer zero overflow logic with apb registers
//
// Contract
// (R1) second priority register: eight per-source bits
// (R2) priority bit one high, zero low
// (R3) priority enable selects two levels or one
// (R4) reset-control bit 5 reads zero
// (R5) reset-control holds reset cause flags
// (R6) reset values follow configuration and reset kind
// (R7) edge select: one rising, zero falling
// (R8) selected edge sets pin flag
// (R9) cleared enable blocks pin interrupt
// (R10) software clears pin flag before re-enable
// (R11) enabled pin interrupt wakes from sleep
// (R12) vector after wake only if global enable
// (R13) pins one, two use own priority bits
// (R14) pin zero always high priority
// (R15) 8-bit overflow FFh to 00h sets flag
// (R16) 16-bit overflow FFFFh to 0000h sets flag
// (R17) timer zero enable gates its interrupt
// (R18) timer zero priority from second control
// (R19) priority bits act only when enabled
// (R20) request needs flag, enable, global permission
`timescale 1ns/10ps
`include "ipes_defines.vh"
module ipes_irq_top #(
	parameter TW = 16 // timer zero width
) (
	input wire pclk, // core clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb byte address
	input wire [31:0] pwdata, // apb write data
	output reg [31:0] prdata, // apb read data
	output reg pready, // apb ready
	output reg pslverr, // apb error on unmapped address
	input wire [2:0] ext_pin, // external interrupt pins
	input wire [TW-1:0] timer_count, // timer zero count
	input wire timer_mode16, // timer zero in 16-bit mode
	input wire [7:0] periph_req, // second-group peripheral requests (flag and enable)
	input wire sleeping, // core in idle or sleep
	input wire power_on_rst, // this reset is a power-on
	input wire brownout_rst, // this reset is a brown-out
	input wire wdt_expired, // watchdog time-out event
	input wire sleep_enter, // sleep instruction executed
	input wire reset_instr, // reset instruction executed
	input wire soft_brownout_enable_cfg, // configuration allows soft brown-out
	output reg irq_high, // high level request
	output reg irq_low, // low level request
	output reg wake // wake-up request to core
);
	//////////////////////////////////////////////////////////////////////
	// registers
	reg [7:0] ppri2_q;
	reg [7:0] rcc_q;
	reg [7:0] ctl1_q;
	reg [7:0] ctl2_q;
	reg [7:0] ctl3_q;
	reg cfg_seen_q;
	reg [2:0] en_at_sleep_q;
	reg sleeping_q;
	wire [2:0] ext_hit;
	wire t0_ovf;
	wire acc;
	wire wr;
	wire mapped;
	wire [7:0] wd;

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign wd = pwdata[7:0];

	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `IPES_OFF_PPRI2) || (a == `IPES_OFF_RCC) ||
				(a == `IPES_OFF_CTL1) || (a == `IPES_OFF_CTL2) ||
				(a == `IPES_OFF_CTL3) || (a == `IPES_OFF_STAT);
		end
	endfunction
	assign mapped = is_mapped(paddr);

	//////////////////////////////////////////////////////////////////////
	// event sources
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_ext
			wire sel;
			if (gi == 0) begin : g0
				assign sel = ctl2_q[`IPES_C2_EDGE0];
			end else if (gi == 1) begin : g1
				assign sel = ctl2_q[`IPES_C2_EDGE1];
			end else begin : g2
				assign sel = ctl2_q[`IPES_C2_EDGE2];
			end
			// (R7) edge polarity select
			ipes_edge_det u_edge (
				.pclk(pclk),
				.presetn(presetn),
				.pin(ext_pin[gi]),
				.rising_sel(sel),
				.hit(ext_hit[gi])
			);
		end
	endgenerate

	// (R15) (R16) overflow detection per mode
	ipes_tmr_ovf #(.W(TW)) u_ovf (
		.pclk(pclk),
		.presetn(presetn),
		.count(timer_count),
		.mode16(timer_mode16),
		.ovf(t0_ovf)
	);

	//////////////////////////////////////////////////////////////////////
	// priority register and control registers
	// (R1) (R2) per-source priority bits
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ppri2_q <= `IPES_RST_PPRI2;
		end else if (wr && paddr == `IPES_OFF_PPRI2) begin
			ppri2_q <= wd;
		end
	end

	// flags: hardware set wins over software clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl1_q <= `IPES_RST_CTL1;
			ctl2_q <= `IPES_RST_CTL2;
			ctl3_q <= `IPES_RST_CTL3;
		end else begin
			if (wr && paddr == `IPES_OFF_CTL1) begin
				ctl1_q <= wd;
			end
			if (wr && paddr == `IPES_OFF_CTL2) begin
				ctl2_q <= wd;
			end
			if (wr && paddr == `IPES_OFF_CTL3) begin
				ctl3_q <= wd;
			end
			// (R8) selected edge sets flag; (R10) only software clears it
			if (ext_hit[0]) begin
				ctl1_q[`IPES_C1_X0IF] <= 1'b1;
			end
			if (ext_hit[1]) begin
				ctl3_q[`IPES_C3_X1IF] <= 1'b1;
			end
			if (ext_hit[2]) begin
				ctl3_q[`IPES_C3_X2IF] <= 1'b1;
			end
			// (R15) (R16) overflow sets timer flag
			if (t0_ovf) begin
				ctl1_q[`IPES_C1_T0IF] <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// reset-cause register
	// (R5) (R6) flags loaded from reset kind and configuration after release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcc_q <= `IPES_RST_RCC_POR;
			cfg_seen_q <= 1'b0;
		end else begin
			if (!cfg_seen_q) begin
				cfg_seen_q <= 1'b1;
				rcc_q[`IPES_RCC_SOFT_BROWNOUT_ENABLE] <= soft_brownout_enable_cfg;
				rcc_q[`IPES_RCC_POR] <= ~power_on_rst;
				rcc_q[`IPES_RCC_BOR] <= ~(power_on_rst | brownout_rst);
				rcc_q[`IPES_RCC_RI] <= ~reset_instr;
				rcc_q[`IPES_RCC_TO] <= ~wdt_expired;
			end else begin
				if (wr && paddr == `IPES_OFF_RCC) begin
					rcc_q[`IPES_RCC_PRIEN] <= wd[`IPES_RCC_PRIEN];
					rcc_q[`IPES_RCC_SOFT_BROWNOUT_ENABLE] <= wd[`IPES_RCC_SOFT_BROWNOUT_ENABLE] & soft_brownout_enable_cfg;
					rcc_q[`IPES_RCC_RI] <= wd[`IPES_RCC_RI];
					rcc_q[`IPES_RCC_POR] <= wd[`IPES_RCC_POR];
					rcc_q[`IPES_RCC_BOR] <= wd[`IPES_RCC_BOR];
				end
				// hardware events win over software writes
				if (wdt_expired) begin
					rcc_q[`IPES_RCC_TO] <= 1'b0;
				end
				if (sleep_enter) begin
					rcc_q[`IPES_RCC_PD] <= 1'b0;
				end
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// request evaluation
	reg [7:0] rd_mux;
	reg hi_d;
	reg lo_d;
	reg wake_d;
	reg single_d;
	reg x0_act;
	reg x1_act;
	reg x2_act;
	reg t0_act;
	reg [7:0] pr_act;
	always @* begin
		// (R9) (R17) (R20) flag and enable both needed
		x0_act = ctl1_q[`IPES_C1_X0IF] & ctl1_q[`IPES_C1_X0IE];
		x1_act = ctl3_q[`IPES_C3_X1IF] & ctl3_q[`IPES_C3_X1IE];
		x2_act = ctl3_q[`IPES_C3_X2IF] & ctl3_q[`IPES_C3_X2IE];
		t0_act = ctl1_q[`IPES_C1_T0IF] & ctl1_q[`IPES_C1_T0IE];
		pr_act = periph_req;
		hi_d = 1'b0;
		lo_d = 1'b0;
		single_d = 1'b0;
		if (rcc_q[`IPES_RCC_PRIEN]) begin
			// (R3) (R19) two levels; global bit gates high, peripheral bit gates low
			// (R14) pin zero always high
			// (R13) (R18) (R2) own priority bits steer level
			hi_d = x0_act |
				(x1_act & ctl3_q[`IPES_C3_X1IP]) |
				(x2_act & ctl3_q[`IPES_C3_X2IP]) |
				(t0_act & ctl2_q[`IPES_C2_T0IP]) |
				(|(pr_act & ppri2_q));
			lo_d = (x1_act & ~ctl3_q[`IPES_C3_X1IP]) |
				(x2_act & ~ctl3_q[`IPES_C3_X2IP]) |
				(t0_act & ~ctl2_q[`IPES_C2_T0IP]) |
				(|(pr_act & ~ppri2_q));
			hi_d = hi_d & ctl1_q[`IPES_C1_GIE];
			lo_d = lo_d & ctl1_q[`IPES_C1_GIE] & ctl1_q[`IPES_C1_PEIE];
		end else begin
			// (R3) single-level compatibility mode, all on high vector
			single_d = x0_act | x1_act | x2_act | t0_act |
				((|pr_act) & ctl1_q[`IPES_C1_PEIE]);
			hi_d = single_d & ctl1_q[`IPES_C1_GIE];
		end
		// (R11) wake from flag of a pin enabled before sleep
		wake_d = sleeping_q & sleeping &
			(|({x2_act, x1_act, x0_act} & en_at_sleep_q) | t0_act);
		rd_mux = 8'h00;
		case (paddr)
			`IPES_OFF_PPRI2: rd_mux = ppri2_q;
			// (R4) unimplemented bit reads zero
			`IPES_OFF_RCC: rd_mux = rcc_q & ~(8'h01 << `IPES_RCC_UNIMP);
			`IPES_OFF_CTL1: rd_mux = ctl1_q;
			`IPES_OFF_CTL2: rd_mux = ctl2_q;
			`IPES_OFF_CTL3: rd_mux = ctl3_q;
			`IPES_OFF_STAT: rd_mux = {7'h00, timer_mode16};
			default: rd_mux = 8'h00;
		endcase
	end

	// enables captured on entry to sleep
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleeping_q <= 1'b0;
			en_at_sleep_q <= 3'h0;
		end else begin
			sleeping_q <= sleeping;
			if (sleeping && !sleeping_q) begin
				en_at_sleep_q <= {ctl3_q[`IPES_C3_X2IE], ctl3_q[`IPES_C3_X1IE],
					ctl1_q[`IPES_C1_X0IE]};
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// outputs and apb answer (zero wait, ready in access phase)
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_high <= 1'b0;
			irq_low <= 1'b0;
			wake <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// (R12) vector only via gated requests; wake alone just resumes
			irq_high <= hi_d;
			irq_low <= lo_d;
			wake <= wake_d;
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			prdata <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_mux} : 32'h00000000;
		end
	end
endmodule // ipes_irq_top

// ### pkg/ipes_defines.vh
// register offsets, field positions and reset values for the interrupt priority block
`ifndef IPES_DEFINES_VH
`define IPES_DEFINES_VH

`define IPES_OFF_PPRI2 12'h000
`define IPES_OFF_RCC 12'h004
`define IPES_OFF_CTL1 12'h008
`define IPES_OFF_CTL2 12'h00c
`define IPES_OFF_CTL3 12'h010
`define IPES_OFF_STAT 12'h014

`define IPES_RST_PPRI2 8'hff
`define IPES_RST_RCC_POR 8'h5c
`define IPES_RST_CTL1 8'h00
`define IPES_RST_CTL2 8'hff
`define IPES_RST_CTL3 8'hc0

// reset_cause_control bits
`define IPES_RCC_PRIEN 7
`define IPES_RCC_SOFT_BROWNOUT_ENABLE 6
`define IPES_RCC_UNIMP 5
`define IPES_RCC_RI 4
`define IPES_RCC_TO 3
`define IPES_RCC_PD 2
`define IPES_RCC_POR 1
`define IPES_RCC_BOR 0

// irq_control_first bits
`define IPES_C1_GIE 7
`define IPES_C1_PEIE 6
`define IPES_C1_T0IE 5
`define IPES_C1_X0IE 4
`define IPES_C1_T0IF 2
`define IPES_C1_X0IF 1

// irq_control_second bits
`define IPES_C2_EDGE0 6
`define IPES_C2_EDGE1 5
`define IPES_C2_EDGE2 4
`define IPES_C2_T0IP 2

// irq_control_third bits
`define IPES_C3_X2IP 7
`define IPES_C3_X1IP 6
`define IPES_C3_X2IE 4
`define IPES_C3_X1IE 3
`define IPES_C3_X2IF 1
`define IPES_C3_X1IF 0

// status register bits
`define IPES_ST_T16 0

`endif

// ### rtl/ipes_edge_det.v
// edge detector for one external interrupt pin with selectable polarity
`timescale 1ns/10ps
module ipes_edge_det (
	input wire pclk, // core clock
	input wire presetn, // async reset, active low
	input wire pin, // external pin level
	input wire rising_sel, // 1 rising, 0 falling
	output wire hit // one-cycle pulse on selected edge
);
	reg prev_q;
	reg armed_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			prev_q <= pin;
			armed_q <= 1'b1;
		end
	end
	// no history in the first cycle after reset, so a pin held high is no edge
	assign hit = armed_q & (rising_sel ? (pin & ~prev_q) : (~pin & prev_q));
endmodule // ipes_edge_det

// ### rtl/ipes_tmr_ovf.v
// timer zero overflow detector for 8-bit and 16-bit counting
`timescale 1ns/10ps
module ipes_tmr_ovf #(
	parameter W = 16 // full counter width
) (
	input wire pclk, // core clock
	input wire presetn, // async reset, active low
	input wire [W-1:0] count, // timer count value
	input wire mode16, // 1 = 16-bit mode
	output wire ovf // one-cycle overflow pulse
);
	reg [W-1:0] prev_q;
	wire all8;
	wire all16;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= {W{1'b0}};
		end else begin
			prev_q <= count;
		end
	end
	assign all8 = (&prev_q[7:0]) & (count[7:0] == 8'h00);
	assign all16 = (&prev_q) & (count == {W{1'b0}});
	assign ovf = mode16 ? all16 : all8;
endmodule // ipes_tmr_ovf

// ### dv/ipes_tmr_src.sv
// timer zero count source feeding the overflow input
`timescale 1ns/10ps
module ipes_tmr_src (
	input wire pclk, // core clock
	input wire run, // count enable
	input wire load, // load start value
	input wire [15:0] start, // start value
	input wire mode16, // 16-bit counting
	output reg [15:0] count // timer value
);
	initial count = 16'h0000;
	// only the low byte counts in 8-bit mode
	always @(posedge pclk) begin
		if (load)
			count <= start;
		else if (run && mode16)
			count <= count + 16'h0001;
		else if (run)
			count[7:0] <= count[7:0] + 8'h01;
	end
endmodule // ipes_tmr_src

// ### dv/ipes_irq_props.sv
// port assertions for the interrupt priority block
`timescale 1ns/10ps
`include "ipes_defines.vh"
module ipes_irq_props (
	input wire pclk, // core clock
	input wire presetn, // async reset, active low
	input wire psel, // apb select
	input wire penable, // apb enable
	input wire pwrite, // apb direction
	input wire [11:0] paddr, // apb address
	input wire [31:0] pwdata, // apb write data
	input wire [31:0] prdata, // apb read data
	input wire pready, // apb ready
	input wire pslverr, // apb error
	input wire irq_high, // high request
	input wire irq_low, // low request
	input wire wake, // wake request
	input wire sleeping // core asleep
);
	reg gie_q, gie_old_q, pri_q, pri_old_q;
	wire wr = psel && penable && pwrite && pready;
	// shadow of global and priority enables, one cycle of lag kept
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gie_q <= 1'b0;
			pri_q <= 1'b0;
			gie_old_q <= 1'b0;
			pri_old_q <= 1'b0;
		end else begin
			if (wr && paddr == `IPES_OFF_CTL1)
				gie_q <= pwdata[7];
			if (wr && paddr == `IPES_OFF_RCC)
				pri_q <= pwdata[7];
			gie_old_q <= gie_q;
			pri_old_q <= pri_q;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ans; psel && !penable |=> pready; endproperty
	a_ans: assert property (p_ans) else $error("no ready after setup");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready longer than one cycle");
	property p_err; psel && !penable && paddr > 12'h014 |=> pslverr && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits not zero");
	property p_rsv; pready && paddr == `IPES_OFF_RCC |-> !prdata[5]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
	property p_gie; !gie_q && !gie_old_q |-> !irq_high && !irq_low; endproperty
	a_gie: assert property (p_gie) else $error("request without global enable");
	property p_lvl; !pri_q && !pri_old_q |-> !irq_low; endproperty
	a_lvl: assert property (p_lvl) else $error("low request in single level");
	property p_wake; !sleeping && !$past(sleeping) |-> !wake; endproperty
	a_wake: assert property (p_wake) else $error("wake while awake");
endmodule // ipes_irq_props
bind ipes_irq_top ipes_irq_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq_high(irq_high), .irq_low(irq_low),
	.wake(wake), .sleeping(sleeping));

// ### dv/ipes_tb.sv
// self-checking bench for the interrupt priority block
`timescale 1ns/10ps
`include "ipes_defines.vh"
module tb;
	reg pclk, presetn, psel, penable, pwrite, rerr, r, mode16, run, load, wdt, slp_in, slp;
	reg [11:0] paddr, a;
	reg [31:0] pwdata, rdata;
	reg [7:0] preq, b, en, fl;
	reg [2:0] ext_pin;
	reg [15:0] start;
	reg cfg_pwr_on, cfg_brown, cfg_rst_ins, cfg_sbo;
	wire [15:0] cnt;
	wire irq_high, irq_low, wake, pready, pslverr;
	wire [31:0] prdata;
	integer fails, n_compared, i;
	ipes_tmr_src u_tmr (.pclk(pclk), .run(run), .load(load), .start(start), .mode16(mode16),
		.count(cnt));
	ipes_irq_top #(.TW(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_pin(ext_pin), .timer_count(cnt),
		.timer_mode16(mode16), .periph_req(preq), .sleeping(slp), .power_on_rst(cfg_pwr_on),
		.brownout_rst(cfg_brown), .wdt_expired(wdt), .sleep_enter(slp_in),
		.reset_instr(cfg_rst_ins), .soft_brownout_enable_cfg(cfg_sbo), .irq_high(irq_high),
		.irq_low(irq_low), .wake(wake));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task tally_and_finish;
		begin
			$display("compared %0d mismatches %0d", n_compared, fails);
			if (fails == 0 && n_compared > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("mismatch at %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge pclk);
	endtask
	// setup cycle, then access until ready is seen at a rising edge
	task apb(input [11:0] ad, input w, input [7:0] d);
		integer n;
		reg ok;
		begin
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= ad;
			pwdata <= {24'h0, d};
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			ok = 1'b0;
			while (ok !== 1'b1 && n < 20) begin
				@(posedge pclk);
				ok = pready;
				rdata = prdata;
				rerr = pslverr;
				n = n + 1;
			end
			if (ok !== 1'b1)
				fails = fails + 1;
			psel <= 1'b0;
			penable <= 1'b0;
			// one idle cycle so the next setup never reassigns in this time step
			@(posedge pclk);
		end
	endtask
	task wr(input [11:0] ad, input [7:0] d);
		apb(ad, 1'b1, d);
	endtask
	task rd(input [11:0] ad, input [7:0] e, input [7:0] m);
		begin
			apb(ad, 1'b0, 8'h00);
			cmp(rdata & {24'hffffff, m}, {24'h0, e & m});
		end
	endtask
	task chk_irq(input [2:0] e);
		begin
			@(negedge pclk);
			cmp({29'h0, irq_high, irq_low, wake}, {29'h0, e});
			@(posedge pclk);
		end
	endtask
	// timer load and run long enough to pass a wrap
	task tmr(input m, input [15:0] v);
		begin
			mode16 <= m;
			start <= v;
			load <= 1'b1;
			tick(1);
			load <= 1'b0;
			run <= 1'b1;
			tick(6);
			run <= 1'b0;
		end
	endtask
	initial begin
		#200000;
		fails = fails + 1;
		tally_and_finish;
	end
	initial begin
		fails = 0;
		n_compared = 0;
		{presetn, psel, penable, pwrite, mode16, run, load, wdt, slp_in, slp} = 10'h0;
		{paddr, pwdata, preq, ext_pin, start} = 0;
		{cfg_pwr_on, cfg_brown, cfg_rst_ins, cfg_sbo} = 4'b1001;
		tick(8);
		presetn <= 1'b1;
		tick(2);
		rd(`IPES_OFF_PPRI2, 8'hff, 8'hff);
		rd(`IPES_OFF_RCC, 8'h5c, 8'hff);
		rd(`IPES_OFF_CTL1, 8'h00, 8'hff);
		rd(`IPES_OFF_CTL2, 8'hff, 8'hff);
		rd(`IPES_OFF_CTL3, 8'hc0, 8'hff);
		apb(12'h018, 1'b0, 8'h00);
		cmp({31'h0, rerr}, 32'h1);
		wr(`IPES_OFF_RCC, 8'hff);
		rd(`IPES_OFF_RCC, 8'h80, 8'ha0);
		$display("registers done");
		wr(`IPES_OFF_CTL1, 8'hc0);
		wr(`IPES_OFF_PPRI2, 8'h55);
		for (i = 0; i < 8; i = i + 1) begin
			preq <= 8'h01 << i;
			tick(2);
			chk_irq({~i[0], i[0], 1'b0});
		end
		wr(`IPES_OFF_RCC, 8'h00);
		tick(1);
		chk_irq(3'b100); // single level
		wr(`IPES_OFF_RCC, 8'h80);
		preq <= 8'h00;
		$display("peripheral priority done");
		for (i = 0; i < 3; i = i + 1) begin
			r = (i != 1);
			a = (i == 0) ? `IPES_OFF_CTL1 : `IPES_OFF_CTL3;
			b = (i == 0) ? 8'hc0 : 8'h80;
			en = (i == 1) ? 8'h08 : 8'h10;
			fl = (i == 1) ? 8'h01 : 8'h02;
			ext_pin[i] <= r;
			wr(`IPES_OFF_CTL2, r ? (8'h40 >> i) : 8'h00);
			wr(a, b | en);
			ext_pin[i] <= ~r;
			tick(3);
			chk_irq(3'b000); // wrong edge
			ext_pin[i] <= r;
			tick(3);
			chk_irq({i != 1, i == 1, 1'b0});
			rd(a, b | en | fl, 8'hff); // flag set
			wr(a, b | fl);
			tick(1);
			chk_irq(3'b000); // enable cleared
			wr(a, b); // flag cleared
		end
		$display("pins done");
		wr(`IPES_OFF_CTL2, 8'h04);
		wr(`IPES_OFF_CTL1, 8'he0);
		tmr(1'b0, 16'h12fd);
		chk_irq(3'b100);
		rd(`IPES_OFF_CTL1, 8'he4, 8'hff);
		wr(`IPES_OFF_CTL1, 8'hc4);
		tick(1);
		chk_irq(3'b000);
		wr(`IPES_OFF_CTL2, 8'h00);
		wr(`IPES_OFF_CTL1, 8'he0);
		tmr(1'b1, 16'h00fd);
		chk_irq(3'b000); // no wrap
		tmr(1'b1, 16'hfffd);
		chk_irq(3'b010);
		rd(`IPES_OFF_STAT, 8'h01, 8'hff); // mode status
		$display("timer done");
		wr(`IPES_OFF_CTL2, 8'h40);
		wr(`IPES_OFF_CTL1, 8'h10);
		ext_pin[0] <= 1'b0;
		tick(3);
		wr(`IPES_OFF_CTL1, 8'h10);
		slp_in <= 1'b1;
		slp <= 1'b1;
		tick(1);
		slp_in <= 1'b0;
		ext_pin[0] <= 1'b1;
		tick(3);
		chk_irq(3'b001);
		slp <= 1'b0;
		rd(`IPES_OFF_RCC, 8'h80, 8'ha4); // power-down flag
		wdt <= 1'b1;
		tick(1);
		wdt <= 1'b0;
		rd(`IPES_OFF_RCC, 8'h80, 8'ha8); // time-out flag
		$display("wake and flags done");
		cfg_pwr_on <= 1'b0;
		cfg_brown <= 1'b1;
		cfg_rst_ins <= 1'b1;
		cfg_sbo <= 1'b0;
		presetn <= 1'b0;
		tick(4);
		presetn <= 1'b1;
		tick(2);
		rd(`IPES_OFF_RCC, 8'h0e, 8'hff); // brown-out after reset instruction
		rd(`IPES_OFF_CTL1, 8'h00, 8'hff); // held pin gives no edge
		rd(`IPES_OFF_CTL3, 8'hc0, 8'hff); // held pin gives no edge
		$display("second reset done");
		tally_and_finish;
	end
endmodule // tb
